// file: hdl/usm_submode_status.sv
/*
  Sub-mode routing and status logic of a serial communications controller,
  with an AXI4-Lite register slave.
  Assumes modem inputs, serial input and both bit clocks are asynchronous pins
  running far slower than clk_sys.
*/
`timescale 1ns/1ps

// What this block does
// - RTS rises one clock after last bit.
// - Normal sub-mode: independent transmitter and receiver.
// - Echo: received data retransmitted, host transmit blocked.
// - Echo only first break character, then mark.
// - Echo: receive clock, ready held, change only.
// - Single sync: strip first sync characters.
// - Double sync: strip sync and following second.
// - Transparent: strip DLE and following sync.
// - Detect bits unaffected by stripping.
// - Local loopback: internal loops, serial, RTS and DTR outputs held high.
// - Remote loopback: retransmit, no host data.
// - Transmit ready reflects holding register state.
// - Receive ready set on load, cleared on read.
// - Empty after character with nothing loaded.
// - DSR or DCD change sets change flag while transmitter or receiver is enabled, outside local loopback.
// - Parity or DLE-sequence flag and its clears.
// - Overrun on unread holding register.
// - Framing error checks first stop bit.
// - Sync detect on sync or DLE-sync.
// - Framing or sync flag clear conditions.
// - Status follows inverted DCD and DSR outside local loopback.
// - Reset-error command clears error flags.
module usm_submode_status
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic transmitClock,
  input wire logic receiveClock,
  input wire logic serialIn,
  input wire logic dcdIn_n,
  input wire logic dsrIn_n,
  input wire logic ctsIn_n,
  output logic serialOut,
  output logic rtsOut_n,
  output logic dtrOut_n,
  output logic txReadyOut_n,
  output logic rxReadyOut_n,
  output logic emptyChangeOut_n,
  output logic [7:0] rxHoldData
);
  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic txcPrev_ff;
  logic rxcPrev_ff;
  assign rawIn = {ctsIn_n, dsrIn_n, dcdIn_n, serialIn, receiveClock, transmitClock};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_ff[gi] <= 1'b1;
          sync2_ff[gi] <= 1'b1;
        end
        else
        begin
          sync1_ff[gi] <= rawIn[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate
  wire txcS = sync2_ff[0];
  wire rxcS = sync2_ff[1];
  wire rxdS = sync2_ff[2];
  wire dcdS_n = sync2_ff[3];
  wire dsrS_n = sync2_ff[4];

  // ==========================================================
  // Registers and decode
  logic [7:0] cmd_ff;
  logic [7:0] mode_ff;
  logic [7:0] first_sync_char_ff;
  logic [7:0] second_sync_char_ff;
  logic [7:0] dle_ff;
  logic [7:0] thr_ff;
  logic thrFull_ff;
  logic rtsHold_ff;
  logic receiver_ready_ff;
  logic emt_ff;
  logic chg_ff;
  logic parDle_ff;
  logic ovr_ff;
  logic frmSyn_ff;
  logic prevDle_ff;
  logic prevSyn1_ff;
  logic inSync_ff;
  logic breakEcho_ff;
  logic [1:0] mdmPrev_ff;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [3:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  wire usm_pkg::usm_sub_t sub = usm_pkg::usm_sub_t'(cmd_ff[7:usm_pkg::USM_CMD_SUB_LO]);
  wire isSync = mode_ff[usm_pkg::USM_MODE_SYNC];
  wire transp = mode_ff[usm_pkg::USM_MODE_TRANSP];
  wire parOn = mode_ff[usm_pkg::USM_MODE_PAR];
  wire oneSyn = mode_ff[usm_pkg::USM_MODE_SYNCNT];
  wire isEcho = sub == usm_pkg::USM_SUB_ECHO && !isSync;
  wire isStrip = sub == usm_pkg::USM_SUB_ECHO && isSync;
  wire isLocal = sub == usm_pkg::USM_SUB_LOCAL;
  wire isRemote = sub == usm_pkg::USM_SUB_REMOTE;
  wire retrans = isEcho || isRemote;
  wire transmitter_enable = cmd_ff[usm_pkg::USM_CMD_TRANSMITTER_ENABLE] && !retrans;
  wire receiver_enable = cmd_ff[usm_pkg::USM_CMD_RECEIVER_ENABLE] || isLocal;
  wire wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  wire rdFire = s_axi_arvalid && s_axi_arready;
  wire wrCmd = wrFire && awAddr_ff == usm_pkg::USM_OFS_COMMAND && wStrb_ff[0];
  wire wrMode = wrFire && awAddr_ff == usm_pkg::USM_OFS_MODE;
  wire wrSyncR = wrFire && awAddr_ff == usm_pkg::USM_OFS_SYNC;
  wire wrThr = wrFire && awAddr_ff == usm_pkg::USM_OFS_STATUS && wStrb_ff[0];
  wire rdStat = rdFire && s_axi_araddr == usm_pkg::USM_OFS_STATUS;
  wire rdHold = rdFire && s_axi_araddr == usm_pkg::USM_OFS_SYNC;
  wire resetErr = wrCmd && wData_ff[usm_pkg::USM_CMD_RSTERR];
  wire [7:0] nxt_cmd = {wData_ff[7:5], 1'b0, wData_ff[3:0]};

  // ==========================================================
  // Clock selection and loops
  wire txClk = retrans ? rxcS : txcS;
  wire rxClk = isLocal ? txcS : rxcS;
  wire bitRise = rxClk && !rxcPrev_ff;
  wire bitFall = !txClk && txcPrev_ff;
  usm_link_if link ();
  wire rxInBit = isLocal ? link.sendBit : rxdS;
  usm_serial_engine u_engine
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bitRise(bitRise),
    .bitFall(bitFall),
    .rxBit(rxInBit),
    .rxOn(receiver_enable),
    .parityOn(parOn),
    .link(link.rx)
  );

  // ==========================================================
  // Character classification
  wire [7:0] ch = link.charData;
  wire isSyn1 = ch == first_sync_char_ff;
  wire isDle = ch == dle_ff && transp;
  wire isSyn2 = ch == second_sync_char_ff && prevSyn1_ff && !oneSyn;
  wire synHit = transp && inSync_ff ? (isSyn1 && prevDle_ff) : (oneSyn ? isSyn1 : isSyn2);
  wire stripSingle = !transp && oneSyn && isSyn1;
  wire stripDouble = !transp && !oneSyn && (isSyn1 || isSyn2);
  wire stripTransp = transp && (isDle || (isSyn1 && prevDle_ff));
  wire strip = isStrip && (stripSingle || stripDouble || stripTransp);
  wire dleSeq = isSync && transp && !parOn && prevDle_ff && !isSyn1 && !isDle;
  wire breakChar = !isSync && link.frameErr && ch == 8'h00;
  wire load = link.charValid && !strip && !isRemote && receiver_enable;
  wire echoLoad = link.charValid && retrans && !(breakChar && !breakEcho_ff);
  wire hostLoad = thrFull_ff && transmitter_enable && !link.txBusy;
  wire mdmChange = {dsrS_n, dcdS_n} != mdmPrev_ff && (transmitter_enable || receiver_enable) && !isLocal;
  assign link.txLoad = echoLoad ? 1'b1 : hostLoad;
  assign link.txData = echoLoad ? ch : thr_ff;

  // ==========================================================
  // Command, mode and holding registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_ff <= usm_pkg::USM_CMD_RST;
      mode_ff <= usm_pkg::USM_MODE_RST;
      first_sync_char_ff <= usm_pkg::USM_FIRST_SYNC_CHAR_RST;
      second_sync_char_ff <= usm_pkg::USM_SECOND_SYNC_CHAR_RST;
      dle_ff <= usm_pkg::USM_DLE_RST;
      thr_ff <= 8'h00;
      thrFull_ff <= 1'b0;
    end
    else
    begin
      if (wrCmd)
        cmd_ff <= nxt_cmd;
      if (wrMode)
        mode_ff <= wData_ff[7:0];
      if (wrSyncR)
      begin
        first_sync_char_ff <= wData_ff[7:0];
        second_sync_char_ff <= wData_ff[15:8];
        dle_ff <= wData_ff[23:16];
      end
      if (wrThr && !retrans)
      begin
        thr_ff <= wData_ff[7:0];
        thrFull_ff <= 1'b1;
      end
      else if (hostLoad)
        thrFull_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receiver_ready_ff <= 1'b0;
      emt_ff <= 1'b0;
      chg_ff <= 1'b0;
      parDle_ff <= 1'b0;
      ovr_ff <= 1'b0;
      frmSyn_ff <= 1'b0;
      prevDle_ff <= 1'b0;
      prevSyn1_ff <= 1'b0;
      inSync_ff <= 1'b0;
      breakEcho_ff <= 1'b1;
      mdmPrev_ff <= 2'h3;
      rxHoldData <= 8'h00;
    end
    else
    begin
      mdmPrev_ff <= {dsrS_n, dcdS_n};
      // Sets are written after clears so an event wins over a clear, except emt_ff, where a holding-register write beats the empty set.
      if (!receiver_enable)
      begin
        receiver_ready_ff <= 1'b0;
        parDle_ff <= 1'b0;
        ovr_ff <= 1'b0;
        frmSyn_ff <= 1'b0;
        inSync_ff <= 1'b0;
      end
      else
      begin
        if (rdHold)
          receiver_ready_ff <= 1'b0;
        if (resetErr)
        begin
          parDle_ff <= 1'b0;
          ovr_ff <= 1'b0;
          if (!isSync)
            frmSyn_ff <= 1'b0;
        end
        if (rdStat && isSync)
          frmSyn_ff <= 1'b0;
        if (link.charValid)
        begin
          prevDle_ff <= isDle && !prevDle_ff;
          prevSyn1_ff <= isSyn1;
          if (isSync && synHit)
          begin
            frmSyn_ff <= 1'b1;
            inSync_ff <= 1'b1;
          end
          if (!isSync && link.frameErr)
            frmSyn_ff <= 1'b1;
          if (load)
            parDle_ff <= parOn ? link.parityErr : dleSeq;
          else if (isRemote && link.parityErr)
            parDle_ff <= 1'b1;
          if (load || isRemote)
            if (receiver_ready_ff && !rdHold)
              ovr_ff <= 1'b1;
          if (load)
          begin
            rxHoldData <= ch;
            receiver_ready_ff <= 1'b1;
          end
        end
        if (link.charValid && !isSync)
          breakEcho_ff <= !breakChar;
      end
      if (rdStat)
        chg_ff <= 1'b0;
      if (mdmChange)
        chg_ff <= 1'b1;
      if (wrThr)
        emt_ff <= 1'b0;
      else if (link.txDone && !thrFull_ff)
        emt_ff <= 1'b1;
    end
  end
  wire transmitter_ready = transmitter_enable && !thrFull_ff;
  wire emtChg = chg_ff || (emt_ff && !isEcho);
  wire [7:0] status = {!dsrS_n && !isLocal, isLocal ? cmd_ff[usm_pkg::USM_CMD_DTR] : !dcdS_n,
    frmSyn_ff, ovr_ff, parDle_ff, emtChg, receiver_ready_ff && !isRemote, transmitter_ready};

  // ==========================================================
  // Modem and serial outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txcPrev_ff <= 1'b1;
      rxcPrev_ff <= 1'b1;
      rtsHold_ff <= 1'b0;
      serialOut <= 1'b1;
      rtsOut_n <= 1'b1;
      dtrOut_n <= 1'b1;
      txReadyOut_n <= 1'b1;
      rxReadyOut_n <= 1'b1;
      emptyChangeOut_n <= 1'b1;
    end
    else
    begin
      txcPrev_ff <= txClk;
      rxcPrev_ff <= rxClk;
      if (wrCmd && cmd_ff[usm_pkg::USM_CMD_RTS] && !wData_ff[usm_pkg::USM_CMD_RTS])
        rtsHold_ff <= link.txBusy;
      else if (cmd_ff[usm_pkg::USM_CMD_RTS])
        rtsHold_ff <= 1'b0;
      else if (bitFall && !link.txBusy)
        rtsHold_ff <= 1'b0;
      serialOut <= isLocal ? 1'b1 : (isEcho && !breakEcho_ff && !link.txBusy) ? 1'b1
        : link.sendBit;
      rtsOut_n <= isLocal || !(cmd_ff[usm_pkg::USM_CMD_RTS] || rtsHold_ff);
      dtrOut_n <= isLocal || !cmd_ff[usm_pkg::USM_CMD_DTR];
      txReadyOut_n <= !transmitter_ready;
      rxReadyOut_n <= !(receiver_ready_ff && !isRemote);
      emptyChangeOut_n <= isRemote || !emtChg;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= usm_pkg::USM_AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= usm_pkg::USM_AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHeld_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awAddr_ff[1:0] != 2'h0 ? usm_pkg::USM_AXI_SLVERR : usm_pkg::USM_AXI_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= s_axi_araddr[1:0] != 2'h0 ? usm_pkg::USM_AXI_SLVERR
          : usm_pkg::USM_AXI_OKAY;
        case (s_axi_araddr)
          usm_pkg::USM_OFS_COMMAND: s_axi_rdata <= {24'h000000, cmd_ff};
          usm_pkg::USM_OFS_STATUS: s_axi_rdata <= {24'h000000, status};
          usm_pkg::USM_OFS_MODE: s_axi_rdata <= {24'h000000, mode_ff};
          usm_pkg::USM_OFS_SYNC: s_axi_rdata <= {24'h000000, rxHoldData};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: pkg/usm_pkg.sv
/*
  Package for the serial controller sub-mode and status block: register offsets,
  field positions, reset values and enumerations.
  Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
*/
package usm_pkg;
  // Register byte addresses.
  localparam logic [3:0] USM_OFS_COMMAND = 4'h0;
  localparam logic [3:0] USM_OFS_STATUS = 4'h4;
  localparam logic [3:0] USM_OFS_MODE = 4'h8;
  localparam logic [3:0] USM_OFS_SYNC = 4'hC;
  // Command register fields.
  localparam int USM_CMD_TRANSMITTER_ENABLE = 0;
  localparam int USM_CMD_DTR = 1;
  localparam int USM_CMD_RECEIVER_ENABLE = 2;
  localparam int USM_CMD_RSTERR = 4;
  localparam int USM_CMD_RTS = 5;
  localparam int USM_CMD_SUB_LO = 6;
  // Mode register fields.
  localparam int USM_MODE_SYNC = 0;
  localparam int USM_MODE_PAR = 4;
  localparam int USM_MODE_TRANSP = 6;
  localparam int USM_MODE_SYNCNT = 7;
  // Status register fields.
  localparam int USM_ST_TRANSMITTER_READY = 0;
  localparam int USM_ST_RECEIVER_READY = 1;
  localparam int USM_ST_EMTCHG = 2;
  localparam int USM_ST_PARDLE = 3;
  localparam int USM_ST_OVR = 4;
  localparam int USM_ST_FRMSYN = 5;
  localparam int USM_ST_DCD = 6;
  localparam int USM_ST_DSR = 7;
  // Reset values.
  localparam logic [7:0] USM_CMD_RST = 8'h00;
  localparam logic [7:0] USM_MODE_RST = 8'h00;
  localparam logic [7:0] USM_FIRST_SYNC_CHAR_RST = 8'h16;
  localparam logic [7:0] USM_SECOND_SYNC_CHAR_RST = 8'h16;
  localparam logic [7:0] USM_DLE_RST = 8'h10;
  localparam logic [1:0] USM_AXI_OKAY = 2'h0;
  localparam logic [1:0] USM_AXI_SLVERR = 2'h2;
  typedef enum logic [1:0]
  {
    USM_SUB_NORMAL,
    USM_SUB_ECHO,
    USM_SUB_LOCAL,
    USM_SUB_REMOTE
  } usm_sub_t;
endpackage

// file: pkg/usm_link_if.sv
/*
  Interface carrying one received character event between the serial
  receiver and the status logic.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface usm_link_if;
  logic charValid;
  logic [7:0] charData;
  logic frameErr;
  logic parityErr;
  logic sendBit;
  logic txBusy;
  logic txDone;
  logic txLoad;
  logic [7:0] txData;
  modport rx
  (
    output charValid,
    output charData,
    output frameErr,
    output parityErr,
    output txBusy,
    output txDone,
    output sendBit,
    input txLoad,
    input txData
  );
  modport ctl
  (
    input charValid,
    input charData,
    input frameErr,
    input parityErr,
    input txBusy,
    input txDone,
    input sendBit,
    output txLoad,
    output txData
  );
endinterface

// file: hdl/usm_serial_engine.sv
/*
  Eight-bit serial engine: samples the serial input at the sampled receive bit clock's
  rising edges and shifts characters out on the sampled transmit bit clock's falling edges.
  Assumes clock and data inputs are already synchronised to clk_sys.
*/
`timescale 1ns/1ps
module usm_serial_engine
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bitRise,
  input wire logic bitFall,
  input wire logic rxBit,
  input wire logic rxOn,
  input wire logic parityOn,
  usm_link_if.rx link
);
  typedef enum logic [1:0] {USM_R_IDLE, USM_R_DATA, USM_R_PAR, USM_R_STOP} usm_rst_t;
  usm_rst_t rxState_ff;
  logic [2:0] rxCnt_ff;
  logic [7:0] rxSh_ff;
  logic rxPar_ff;
  logic [3:0] txCnt_ff;
  logic [8:0] txSh_ff;
  logic [7:0] frame;
  logic txActive;
  assign txActive = txCnt_ff != 4'h0;
  assign frame = rxSh_ff;

  // ==========================================================
  // Receiver
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState_ff <= USM_R_IDLE;
      rxCnt_ff <= 3'h0;
      rxSh_ff <= 8'h00;
      rxPar_ff <= 1'b0;
      link.charValid <= 1'b0;
      link.frameErr <= 1'b0;
      link.parityErr <= 1'b0;
    end
    else
    begin
      link.charValid <= 1'b0;
      if (!rxOn)
        rxState_ff <= USM_R_IDLE;
      else if (bitRise)
        case (rxState_ff)
          USM_R_IDLE:
          begin
            rxCnt_ff <= 3'h0;
            rxPar_ff <= 1'b0;
            if (!rxBit)
              rxState_ff <= USM_R_DATA;
          end
          USM_R_DATA:
          begin
            rxSh_ff <= {rxBit, rxSh_ff[7:1]};
            rxPar_ff <= rxPar_ff ^ rxBit;
            rxCnt_ff <= rxCnt_ff + 3'h1;
            if (rxCnt_ff == 3'h7)
              rxState_ff <= parityOn ? USM_R_PAR : USM_R_STOP;
          end
          USM_R_PAR:
          begin
            link.parityErr <= rxPar_ff ^ rxBit;
            rxState_ff <= USM_R_STOP;
          end
          default:
          begin
            // Only the first stop bit is checked.
            link.frameErr <= !rxBit;
            link.charData <= frame;
            link.charValid <= 1'b1;
            if (!parityOn)
              link.parityErr <= 1'b0;
            rxState_ff <= USM_R_IDLE;
          end
        endcase
    end
  end

  // ==========================================================
  // Transmitter
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txCnt_ff <= 4'h0;
      txSh_ff <= 9'h1FF;
      link.sendBit <= 1'b1;
      link.txDone <= 1'b0;
      link.txBusy <= 1'b0;
    end
    else
    begin
      link.txDone <= 1'b0;
      link.txBusy <= txActive || link.txLoad;
      if (link.txLoad && !txActive)
      begin
        txSh_ff <= {link.txData, 1'b0};
        txCnt_ff <= 4'hA;
      end
      else if (bitFall && txActive)
      begin
        link.sendBit <= txSh_ff[0];
        txSh_ff <= {1'b1, txSh_ff[8:1]};
        txCnt_ff <= txCnt_ff - 4'h1;
        if (txCnt_ff == 4'h1)
          link.txDone <= 1'b1;
      end
    end
  end
endmodule

// file: sim/usm_submode_status_asserts.sv
/* Port checks for usm_submode_status, bound at the foot of this file.
   Assumes AXI masters offer write address and write data together. */
`timescale 1ns/1ps
module usm_submode_status_asserts
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dcdIn_n,
  input wire logic dsrIn_n,
  input wire logic serialOut,
  input wire logic rtsOut_n,
  input wire logic dtrOut_n,
  input wire logic txReadyOut_n,
  input wire logic rxReadyOut_n,
  input wire logic emptyChangeOut_n
);
  logic [7:0] cmd_ff, nxt_cmd;
  logic [3:0] rdAddr_ff, nxt_rdAddr, stbl_ff, nxt_stbl;
  logic [1:0] lines_ff, sub;
  // The line check waits for quiet modem inputs because they cross two synchroniser flops.
  assign nxt_cmd = (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h0) ?
    s_axi_wdata[7:0] : cmd_ff;
  assign nxt_rdAddr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rdAddr_ff;
  assign nxt_stbl = (lines_ff != {dsrIn_n, dcdIn_n}) ? 4'h0 : stbl_ff + {3'h0, stbl_ff != 4'hF};
  assign sub = cmd_ff[7:6];
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      {cmd_ff, rdAddr_ff, lines_ff, stbl_ff} <= 18'h00000;
    else
      {cmd_ff, rdAddr_ff, lines_ff, stbl_ff} <= {nxt_cmd, nxt_rdAddr, dsrIn_n, dcdIn_n, nxt_stbl};
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ========
  // Assertions
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_rx_clear:
    assert property (s_axi_rvalid && s_axi_rready && rdAddr_ff == 4'hC |-> ##[1:3] rxReadyOut_n)
    else $error("receive ready pin stuck after read");
  a_line_status:
    assert property (s_axi_rvalid && rdAddr_ff == 4'h4 && stbl_ff == 4'hF && sub != 2'b10
      |-> s_axi_rdata[7:6] == ~{dsrIn_n, dcdIn_n})
    else $error("modem status bits wrong");
  a_remote_pins:
    assert property ((sub == 2'b11) [*4] |-> txReadyOut_n && rxReadyOut_n && emptyChangeOut_n)
    else $error("status pin active in remote loop");
  a_local_pins:
    assert property ((sub == 2'b10) [*3] |-> serialOut && rtsOut_n && dtrOut_n)
    else $error("output low in local loop");
  a_dtr_level:
    assert property ((sub != 2'b10 && $stable(cmd_ff)) [*3] |-> dtrOut_n == !cmd_ff[1])
    else $error("terminal ready pin wrong");
endmodule

bind usm_submode_status usm_submode_status_asserts u_chk
(
  .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .dcdIn_n, .dsrIn_n, .serialOut, .rtsOut_n, .dtrOut_n,
  .txReadyOut_n, .rxReadyOut_n, .emptyChangeOut_n
);

// file: sim/usm_modem_model.sv
/* Behavioural modem: frames characters with bit clocks and drives the modem lines.
   Assumes the receiver samples the line on the receive clock rising edge. */
`timescale 1ns/1ps
module usm_modem_model
(
  output logic receiveClock,
  output logic transmitClock,
  output logic serialIn,
  output logic dcdIn_n,
  output logic dsrIn_n
);
  initial
  begin
    {receiveClock, transmitClock, dcdIn_n, dsrIn_n} = 4'h0;
    serialIn = 1'b1;
  end
  // Clocks run only inside a frame; two mark bits lead in so a freshly enabled receiver can hunt.
  task automatic send_char(input logic [7:0] d, input logic stopBit);
    logic [11:0] bits;
    bits = {stopBit, d, 1'b0, 2'b11};
    for (int i = 0; i < 12; i++)
    begin
      serialIn = bits[i];
      #80 {receiveClock, transmitClock} = 2'b11;
      #80 {receiveClock, transmitClock} = 2'b00;
    end
    serialIn = 1'b1;
  endtask
  task automatic set_dsr(input logic v);
    dsrIn_n = v;
  endtask
endmodule

// file: sim/test_usm_submode_status.sv
/* Self-checking bench for usm_submode_status with a modem model on the line side.
   Assumes a 250 MHz system clock and a 160 ns link bit period. */
`timescale 1ns/1ps
module test_usm_submode_status;
  typedef struct packed
  {
    logic wr;
    logic [3:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] rs;
  } usm_row_t;
  logic clk_sys, rst_n, ctsIn_n, transmitClock, receiveClock, serialIn, dcdIn_n, dsrIn_n;
  logic serialOut, rtsOut_n, dtrOut_n, txReadyOut_n, rxReadyOut_n, emptyChangeOut_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdV;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsV;
  logic [7:0] rxHoldData;
  int n_fail, tests_run;
  usm_row_t rows [6];
  usm_submode_status u_dut
  (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .transmitClock, .receiveClock, .serialIn, .dcdIn_n,
    .dsrIn_n, .ctsIn_n, .serialOut, .rtsOut_n, .dtrOut_n, .txReadyOut_n, .rxReadyOut_n,
    .emptyChangeOut_n, .rxHoldData
  );
  usm_modem_model u_peer
  (
    .receiveClock, .transmitClock, .serialIn, .dcdIn_n, .dsrIn_n
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ========
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One transfer, write or read; each channel is released at the edge that takes it.
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {wr, wr, wr};
    {s_axi_arvalid, s_axi_rready} <= {!wr, !wr};
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid)
        break;
    end
    rdV = s_axi_rdata;
    rsV = wr ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (k == 50)
    begin
      check(32'h1, 32'h0);
      complete_run;
    end
  endtask
  task automatic wait_rx;
    for (int k = 0; k < 200 && rxReadyOut_n !== 1'b0; k++)
      @(posedge clk_sys);
    if (rxReadyOut_n !== 1'b0)
    begin
      check(32'h1, 32'h0);
      complete_run;
    end
  endtask
  // ========
  // Main sequence
  initial
  begin
    rows = '{'{1'b0, 4'h0, 32'h0, 32'hFF, usm_pkg::USM_AXI_OKAY},
      '{1'b1, 4'h8, 32'h0, 32'h0, usm_pkg::USM_AXI_OKAY},
      '{1'b1, 4'h0, 32'h37, 32'h0, usm_pkg::USM_AXI_OKAY},
      '{1'b0, 4'h0, 32'h27, 32'hFFFFFFFF, usm_pkg::USM_AXI_OKAY},
      '{1'b0, 4'h2, 32'h0, 32'h0, usm_pkg::USM_AXI_SLVERR},
      '{1'b0, 4'h4, 32'hC1, 32'hFF, usm_pkg::USM_AXI_OKAY}};
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ctsIn_n} = 41'h0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      axi(rows[i].wr, rows[i].a, rows[i].d);
      check(rdV & rows[i].m, rows[i].d & rows[i].m);
      check(rsV, rows[i].rs);
    end
    check({txReadyOut_n, rtsOut_n, dtrOut_n}, 3'b000);
    u_peer.send_char(8'h5A, 1'b1);
    wait_rx;
    check(rxHoldData, 8'h5A);
    u_peer.send_char(8'hA5, 1'b1);
    axi(1'b0, 4'h4, 32'h0);
    check(rdV, 32'hD3);
    axi(1'b0, 4'hC, 32'h0);
    check(rdV, 32'hA5);
    axi(1'b1, 4'h0, 32'h37);
    axi(1'b0, 4'h4, 32'h0);
    check(rdV, 32'hC1);
    u_peer.send_char(8'h00, 1'b0);
    wait_rx;
    axi(1'b0, 4'h4, 32'h0);
    check(rdV, 32'hE3);
    axi(1'b0, 4'hC, 32'h0);
    check(rdV, 32'h0);
    axi(1'b1, 4'h0, 32'h37);
    axi(1'b0, 4'h4, 32'h0);
    check(rdV, 32'hC1);
    u_peer.set_dsr(1'b1);
    repeat (20) @(posedge clk_sys);
    check(emptyChangeOut_n, 1'b0);
    axi(1'b0, 4'h4, 32'h0);
    check(rdV, 32'h45);
    axi(1'b0, 4'h4, 32'h0);
    check(rdV, 32'h41);
    axi(1'b1, 4'h4, 32'h55);
    axi(1'b1, 4'h0, 32'h17);
    check(rtsOut_n, 1'b0);
    u_peer.send_char(8'hFF, 1'b1);
    check(rtsOut_n, 1'b1);
    axi(1'b1, 4'h0, 32'hC4);
    u_peer.send_char(8'h3C, 1'b1);
    repeat (20) @(posedge clk_sys);
    check({txReadyOut_n, rxReadyOut_n, emptyChangeOut_n, rxHoldData}, 11'h7FF);
    axi(1'b1, 4'h0, 32'hA3);
    repeat (4) @(posedge clk_sys);
    check({serialOut, rtsOut_n, dtrOut_n}, 3'b111);
    complete_run;
  end
endmodule
